// File: tsg_pkg.sv
// Package: register map, field positions and carrier types for the trap/irq control block
// Function
// - Address fault sets bit 3, else zero
// - Stack fault sets bit 2, else zero
// - Oscillator loss sets bit 1, else zero
// - Unimplemented bits read back as zero
// - Software trap control bit 13, resets zero
// - Edge select: one falling, zero rising
package tsg_pkg;

  // Register byte offsets
  localparam logic [7:0] TRAP_STATUS_OFF = 8'h00;
  localparam logic [7:0] GLOBAL_CTRL_OFF = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFF  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF    = 8'h0C;

  // Trap status field positions
  localparam int ADDR_FAULT_BIT = 3;
  localparam int STACK_FAULT_BIT = 2;
  localparam int OSC_LOSS_BIT   = 1;

  // Global control field positions
  localparam int GIE_BIT    = 15;
  localparam int SOFTWARE_TRAP_CONTROL_BIT = 13;
  localparam int NUM_EXT    = 3;

  // Implemented bits of the trap status and global control registers
  localparam logic [15:0] TRAP_STATUS_MASK = 16'h000E;
  localparam logic [15:0] GLOBAL_CTRL_MASK = 16'hA007;

  // Reset values
  localparam logic [15:0] TRAP_STATUS_RST = 16'h0000;
  localparam logic [15:0] GLOBAL_CTRL_RST = 16'h8000;
  localparam logic [5:0]  IRQ_STATUS_RST  = 6'h00;
  localparam logic [5:0]  IRQ_MASK_RST    = 6'h00;

  // Interrupt status/mask layout: bits 2:0 traps addr/stack/osc, 5:3 external edges
  localparam int IRQ_W = 6;

  // AHB transfer codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Hardware trap event group
  typedef struct packed {
    logic addr_fault;
    logic stack_fault;
    logic osc_loss;
  } tsg_trap_ev_t;

endpackage : tsg_pkg

// File: tsg_edge_detect.sv
// Edge detector with selectable polarity for one external interrupt input
`timescale 1ns/1ps
`default_nettype none
module tsg_edge_detect (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin and polarity
  input  wire logic pin_in,
  input  wire logic falling_sel,
  // Detected edge pulse
  output logic      edge_pulse
);

  logic prev_reg;
  logic armed_reg;

  // Held off for the first cycle after reset, before prev_reg follows the pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end

  // Previous pin level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_in;
    end
  end

  // Select falling or rising edge
  always_comb begin
    if (falling_sel) begin
      edge_pulse = armed_reg & prev_reg & ~pin_in;
    end else begin
      edge_pulse = armed_reg & ~prev_reg & pin_in;
    end
  end

endmodule : tsg_edge_detect
`default_nettype wire

// File: tsg_trap_irq_ctrl.sv
// Top: trap status flags, global irq control, edge selects and AHB-Lite slave
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tsg_trap_irq_ctrl #(
  parameter int NUM_EXT = tsg_pkg::NUM_EXT
) (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Trap events from the core
  input  wire tsg_pkg::tsg_trap_ev_t trap_ev,
  // External interrupt pins
  input  wire logic [NUM_EXT-1:0]   ext_irq_pin,
  // Interrupt requests towards the core
  input  wire logic [NUM_EXT-1:0]   periph_irq,
  output logic                      core_irq_req,
  output logic [NUM_EXT-1:0]        ext_irq_event,
  output logic                      trap_pending,
  output logic                      software_trap_control,
  output logic                      irq_out
);

  logic [15:0]         trap_status_reg;
  logic [15:0]         global_ctrl_reg;
  logic [5:0]          irq_status_reg;
  logic [5:0]          irq_mask_reg;
  logic                wr_pend_reg;
  logic [7:0]          wr_addr_reg;
  logic [NUM_EXT-1:0]  ext_edge;
  logic [NUM_EXT-1:0]  ext_sel;
  logic                addr_phase;
  logic                wr_trap;
  logic                wr_gctl;
  logic                wr_ists;
  logic                wr_imsk;
  logic [15:0]         trap_set;
  logic [5:0]          irq_set;
  logic [31:0]         rd_next;

  // Decode an address phase that reaches this slave
  assign addr_phase = hsel & hready & (htrans == tsg_pkg::HTRANS_NONSEQ);

  // Register select: low address byte against one register offset
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] offset);
    reg_hit = (addr == offset);
  endfunction : reg_hit

  // Write strobes in the data phase
  assign wr_trap = wr_pend_reg & reg_hit(wr_addr_reg, tsg_pkg::TRAP_STATUS_OFF);
  assign wr_gctl = wr_pend_reg & reg_hit(wr_addr_reg, tsg_pkg::GLOBAL_CTRL_OFF);
  assign wr_ists = wr_pend_reg & reg_hit(wr_addr_reg, tsg_pkg::IRQ_STATUS_OFF);
  assign wr_imsk = wr_pend_reg & reg_hit(wr_addr_reg, tsg_pkg::IRQ_MASK_OFF);

  // Polarity selects from the control register
  assign ext_sel = global_ctrl_reg[NUM_EXT-1:0];

  // One edge detector per external pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      tsg_edge_detect u_edge (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .pin_in      (ext_irq_pin[gi]),
        .falling_sel (ext_sel[gi]),
        .edge_pulse  (ext_edge[gi])
      );
    end
  endgenerate

  // Hardware trap set terms
  always_comb begin
    trap_set = 16'h0000;
    trap_set[tsg_pkg::ADDR_FAULT_BIT]  = trap_ev.addr_fault;
    trap_set[tsg_pkg::STACK_FAULT_BIT] = trap_ev.stack_fault;
    trap_set[tsg_pkg::OSC_LOSS_BIT]    = trap_ev.osc_loss;
  end

  // Capture write address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  // Trap flags: set by hardware, cleared by writing zero; set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap_status_reg <= tsg_pkg::TRAP_STATUS_RST;
    end else if (wr_trap) begin
      trap_status_reg <= ((trap_status_reg & hwdata[15:0]) | trap_set)
                         & tsg_pkg::TRAP_STATUS_MASK;
    end else begin
      trap_status_reg <= (trap_status_reg | trap_set)
                         & tsg_pkg::TRAP_STATUS_MASK;
    end
  end

  // Global control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_ctrl_reg <= tsg_pkg::GLOBAL_CTRL_RST;
    end else if (wr_gctl) begin
      global_ctrl_reg <= hwdata[15:0] & tsg_pkg::GLOBAL_CTRL_MASK;
    end
  end

  // Interrupt status events: traps and external edges
  assign irq_set = {ext_edge, trap_ev.addr_fault, trap_ev.stack_fault, trap_ev.osc_loss};

  // Sticky interrupt status, write one to clear; set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= tsg_pkg::IRQ_STATUS_RST;
    end else if (wr_ists) begin
      irq_status_reg <= (irq_status_reg & ~hwdata[5:0]) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  // Interrupt mask register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= tsg_pkg::IRQ_MASK_RST;
    end else if (wr_imsk) begin
      irq_mask_reg <= hwdata[5:0];
    end
  end

  // Read data mux, unmapped reads zero
  always_comb begin
    rd_next = 32'h0000_0000;
    case (haddr[7:0])
      tsg_pkg::TRAP_STATUS_OFF: rd_next = {16'h0000, trap_status_reg};
      tsg_pkg::GLOBAL_CTRL_OFF: rd_next = {16'h0000, global_ctrl_reg};
      tsg_pkg::IRQ_STATUS_OFF:  rd_next = {26'h000_0000, irq_status_reg};
      tsg_pkg::IRQ_MASK_OFF:    rd_next = {26'h000_0000, irq_mask_reg};
      default:                  rd_next = 32'h0000_0000;
    endcase
  end

  // Registered read data for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= rd_next;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Ordinary interrupt request: global enable gates it, traps never pass here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_irq_req <= 1'b0;
    end else begin
      core_irq_req <= global_ctrl_reg[tsg_pkg::GIE_BIT]
                      & ((|periph_irq) | (|ext_edge));
    end
  end

  // One-cycle pulse per detected external edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_irq_event <= '0;
    end else begin
      ext_irq_event <= ext_edge;
    end
  end

  // Trap pending ignores the global enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap_pending <= 1'b0;
    end else begin
      trap_pending <= |trap_status_reg;
    end
  end

  // Software trap enable towards the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      software_trap_control <= 1'b0;
    end else begin
      software_trap_control <= global_ctrl_reg[tsg_pkg::SOFTWARE_TRAP_CONTROL_BIT];
    end
  end

  // Level interrupt output from unmasked status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule : tsg_trap_irq_ctrl
`default_nettype wire

// File: tsg_trap_irq_ctrl_chk.sv
// Checker: port-level properties of the trap and irq control block
`timescale 1ns/1ps
`default_nettype none
module tsg_trap_irq_ctrl_chk #(
  parameter int NUM_EXT = 3
) (
  // Clock, reset and bus
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic                  hwrite,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  // Events and status outputs
  input wire tsg_pkg::tsg_trap_ev_t trap_ev,
  input wire logic [NUM_EXT-1:0]    ext_irq_pin,
  input wire logic [NUM_EXT-1:0]    ext_irq_event,
  input wire logic                  trap_pending,
  input wire logic                  software_trap_control
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus idle long enough that no write is still landing
  sequence s_quiet; (!hsel)[*4]; endsequence
  // Pins held still long enough that no edge is in flight
  sequence s_still; $stable(ext_irq_pin)[*6]; endsequence
  property p_addr; trap_ev.addr_fault |-> ##2 trap_pending; endproperty
  a_addr: assert property (p_addr) else $error("address fault lost");
  property p_stk; trap_ev.stack_fault |-> ##2 trap_pending; endproperty
  a_stk: assert property (p_stk) else $error("stack fault lost");
  property p_osc; trap_ev.osc_loss |-> ##2 trap_pending; endproperty
  a_osc: assert property (p_osc) else $error("osc loss lost");
  property p_hold; $fell(trap_pending) |-> $past(hsel, 3) && $past(hwrite, 3); endproperty
  a_hold: assert property (p_hold) else $error("trap flag dropped alone");
  property p_upper; hrdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_sw; s_quiet |-> $stable(software_trap_control); endproperty
  a_sw: assert property (p_sw) else $error("software_trap_control moved without write");
  property p_ext; s_still |=> ext_irq_event == '0; endproperty
  a_ext: assert property (p_ext) else $error("edge event without edge");
  property p_rdy; hreadyout && !hresp; endproperty
  a_rdy: assert property (p_rdy) else $error("bus not ready or error");
endmodule : tsg_trap_irq_ctrl_chk
`default_nettype wire

// File: tsg_trap_irq_ctrl_tb.sv
// Testbench: registers, traps, global enable and edge selects
`timescale 1ns/1ps
`default_nettype none
module tsg_trap_irq_ctrl_tb;
  localparam logic [7:0] TS = tsg_pkg::TRAP_STATUS_OFF;
  localparam logic [7:0] GC = tsg_pkg::GLOBAL_CTRL_OFF;
  localparam logic [7:0] IS = tsg_pkg::IRQ_STATUS_OFF;
  localparam logic [7:0] IM = tsg_pkg::IRQ_MASK_OFF;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  trap_ev = 3'h0;
  logic [2:0]  pin = 3'h0;
  logic [2:0]  periph_irq = 3'h0;
  logic        core_irq_req;
  logic [2:0]  ext_ev;
  logic        trap_pending;
  logic        swt;
  logic        irq_out;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          checked = 0;
  // Clock
  always #12.5 hclk = ~hclk;
  tsg_trap_irq_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trap_ev(trap_ev),
    .ext_irq_pin(pin), .periph_irq(periph_irq), .core_irq_req(core_irq_req),
    .ext_irq_event(ext_ev), .trap_pending(trap_pending), .software_trap_control(swt),
    .irq_out(irq_out));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One single AHB-Lite word transfer; read data lands in rd
  task automatic rw(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= tsg_pkg::HTRANS_NONSEQ;
    hsize  <= tsg_pkg::HSIZE_WORD;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : rw
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : idle
  task automatic t_regs;
    rw(TS, 0, 0); chk("trap_status_low", 32'h0000_0000, rd);
    rw(GC, 0, 0); chk("global_irq_control", 32'h0000_8000, rd);
    rw(GC, 1, 32'hFFFF_FFFF); rw(GC, 0, 0); chk("ctrl", 32'h0000_A007, rd);
    idle(2); chk("software_trap_control", 1, swt);
    rw(TS, 1, 32'hFFFF_FFFF); rw(TS, 0, 0); chk("trap ro", 0, rd);
    rw(8'h10, 1, 32'hFFFF_FFFF); rw(8'h10, 0, 0); chk("unmapped", 0, rd);
    rw(GC, 1, 32'h0000_8000); idle(2); chk("software_trap_control", 0, swt);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_traps;
    for (int i = 0; i < 3; i++) begin
      @(posedge hclk);
      trap_ev <= 3'h4 >> i;
      @(posedge hclk);
      trap_ev <= 3'h0;
      idle(3);
      chk("trap_pending", 1, trap_pending);
      rw(TS, 1, 32'h0000_000E); rw(TS, 0, 0); chk("flag", 32'h8 >> i, rd);
      rw(TS, 1, 0); idle(3); chk("trap_pending", 0, trap_pending);
    end
    chk("irq_out", 0, irq_out);
    rw(IM, 1, 32'h0000_0007); idle(2); chk("irq_out", 1, irq_out);
    rw(IS, 1, 32'h0000_0007); idle(2); chk("irq_out", 0, irq_out);
    $display("t_traps done");
  endtask : t_traps
  task automatic t_gie;
    @(posedge hclk);
    periph_irq <= 3'h1;
    idle(3); chk("core_irq_req", 1, core_irq_req);
    rw(GC, 1, 0); idle(3); chk("core_irq_req", 0, core_irq_req);
    @(posedge hclk);
    trap_ev <= 3'h2;
    @(posedge hclk);
    trap_ev <= 3'h0;
    idle(3); chk("trap_pending", 1, trap_pending);
    @(posedge hclk);
    periph_irq <= 3'h0;
    rw(TS, 1, 0); rw(GC, 1, 32'h0000_8000);
    $display("t_gie done");
  endtask : t_gie
  task automatic t_edge;
    for (int s = 0; s < 2; s++) for (int i = 0; i < 3; i++) begin
      rw(GC, 1, 32'h0000_8000 | {29'h0, {3{s[0]}}});
      pin <= {3{s[0]}};
      idle(6); rw(IS, 1, 32'h0000_003F);
      pin[i] <= ~s[0];
      idle(1); chk("ext_irq_event", 32'h1 << i, ext_ev);
      idle(5); rw(IS, 0, 0); chk("edge hit", 32'h8 << i, rd);
      rw(IS, 1, 32'h0000_003F);
      pin[i] <= s[0];
      idle(1); chk("ext_irq_event", 0, ext_ev);
      idle(5); rw(IS, 0, 0); chk("edge miss", 0, rd);
    end
    $display("t_edge done");
  endtask : t_edge
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_traps;
    t_gie;
    t_edge;
    complete_run;
  end
  // Watchdog
  initial begin
    #200us;
    error_cnt++;
    complete_run;
  end
endmodule : tsg_trap_irq_ctrl_tb
bind tsg_trap_irq_ctrl tsg_trap_irq_ctrl_chk #(.NUM_EXT(NUM_EXT)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .trap_ev(trap_ev), .ext_irq_pin(ext_irq_pin), .ext_irq_event(ext_irq_event),
  .trap_pending(trap_pending), .software_trap_control(software_trap_control));
`default_nettype wire
